/* File: hw/awc_pkg.sv */
// Package for the converter window comparator: register map, reset values, widths, timing.
// Assumes an 8-bit special-function register port and a 16-bit conversion word.
package awc_pkg;

  // ----------------------------------------
  // Register addresses (8-bit register space)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'hE8;
  localparam logic [7:0] ADDR_GT_HI = 8'hC3;
  localparam logic [7:0] ADDR_GT_LO = 8'hC4;
  localparam logic [7:0] ADDR_LT_LO = 8'hC5;
  localparam logic [7:0] ADDR_LT_HI = 8'hC6;
  localparam logic [7:0] ADDR_RES_HI = 8'hBE;
  localparam logic [7:0] ADDR_RES_LO = 8'hBD;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hE9;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hEA;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_GT_BYTE = 8'hFF;
  localparam logic [7:0] RST_LT_BYTE = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_WIN_BIT = 3;
  localparam int CTRL_DIFF_BIT = 7;
  localparam int IRQ_WIN_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;

  // ----------------------------------------
  // Widths and timing
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int SE_BITS = 10;
  localparam int DIFF_BITS = 12;
  localparam int MIN_CONV_CLKS = 10;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } awc_bus_s;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] word;
  } awc_conv_s;

endpackage : awc_pkg

/* File: hw/awc_window_cmp.sv */
// Converter window comparator: limit registers, result capture, sticky window flag, interrupt.
// Assumes a register port with one-cycle strobes and conversions delivered as one-cycle pulses.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps

module awc_window_cmp #(
  parameter int MIN_CONV = awc_pkg::MIN_CONV_CLKS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire awc_pkg::awc_bus_s bus,
  output logic [7:0] rdata,
  input wire awc_pkg::awc_conv_s conv,
  input wire logic conv_clk_tick,
  input wire logic diff_mode,
  output logic window_irq
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] lt_lo_q;
  logic [7:0] lt_hi_q;
  logic [7:0] gt_lo_q;
  logic [7:0] gt_hi_q;
  logic [7:0] res_lo_q;
  logic [7:0] res_hi_q;
  logic [7:0] rdata_q;
  logic win_flag_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic irq_q;
  logic diff_q;
  logic cmp_pend_q;
  logic [7:0] conv_cnt_q;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire wr_ctrl = bus.wr && bus.addr == awc_pkg::ADDR_CTRL;
  wire wr_gt_hi = bus.wr && bus.addr == awc_pkg::ADDR_GT_HI;
  wire wr_gt_lo = bus.wr && bus.addr == awc_pkg::ADDR_GT_LO;
  wire wr_lt_lo = bus.wr && bus.addr == awc_pkg::ADDR_LT_LO;
  wire wr_lt_hi = bus.wr && bus.addr == awc_pkg::ADDR_LT_HI;
  wire wr_stat = bus.wr && bus.addr == awc_pkg::ADDR_IRQ_STAT;
  wire wr_mask = bus.wr && bus.addr == awc_pkg::ADDR_IRQ_MASK;

  // ----------------------------------------
  // Conversion length guard
  // ----------------------------------------
  // Converter clock ticks counted since the last result; early results are discarded
  wire conv_long_enough = conv_cnt_q >= 8'(MIN_CONV);
  wire take_result = conv.valid && conv_long_enough;
  // Counter stops at the minimum, so eight bits never wrap

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_cnt_q <= awc_pkg::RST_ZERO;
    end else if (take_result) begin
      conv_cnt_q <= awc_pkg::RST_ZERO;
    end else if (conv_clk_tick && !conv_long_enough) begin
      conv_cnt_q <= conv_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------
  // Comparison
  // ----------------------------------------
  wire [15:0] res_w = {res_hi_q, res_lo_q};
  wire [15:0] gt_w = {gt_hi_q, gt_lo_q};
  wire [15:0] lt_w = {lt_hi_q, lt_lo_q};
  // Signed view flips the sign bit so one unsigned comparator serves both modes
  // Limitation: differential words must arrive sign-extended to sixteen bits
  wire [15:0] sflip = diff_q ? 16'h8000 : 16'h0000;
  wire [15:0] res_c = res_w ^ sflip;
  wire [15:0] gt_c = gt_w ^ sflip;
  wire [15:0] lt_c = lt_w ^ sflip;
  wire above_gt = res_c > gt_c;
  wire below_lt = res_c < lt_c;
  wire inside_win = lt_c > gt_c;
  wire hit_inside = above_gt && below_lt;
  wire hit_outside = (res_c < gt_c) || (res_c > lt_c);
  wire win_hit = inside_win ? hit_inside : hit_outside;
  wire win_event = cmp_pend_q && win_hit;

  // ----------------------------------------
  // Result capture and flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      res_lo_q <= awc_pkg::RST_ZERO;
      res_hi_q <= awc_pkg::RST_ZERO;
      diff_q <= 1'b0;
      cmp_pend_q <= 1'b0;
    end else begin
      cmp_pend_q <= take_result;
      if (take_result) begin
        res_lo_q <= conv.word[7:0];
        res_hi_q <= conv.word[15:8];
        diff_q <= diff_mode;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lt_lo_q <= awc_pkg::RST_LT_BYTE;
    end else if (wr_lt_lo) begin
      lt_lo_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lt_hi_q <= awc_pkg::RST_LT_BYTE;
    end else if (wr_lt_hi) begin
      lt_hi_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gt_lo_q <= awc_pkg::RST_GT_BYTE;
    end else if (wr_gt_lo) begin
      gt_lo_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gt_hi_q <= awc_pkg::RST_GT_BYTE;
    end else if (wr_gt_hi) begin
      gt_hi_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_mask_q <= 2'h0;
    end else if (wr_mask) begin
      irq_mask_q <= bus.wdata[1:0];
    end
  end

  // Set beats clear so a match in the clearing cycle is not lost
  wire flag_clr = wr_ctrl && !bus.wdata[awc_pkg::CTRL_WIN_BIT];
  wire [1:0] stat_set = {cmp_pend_q, win_event};
  wire [1:0] stat_clr = wr_stat ? bus.wdata[1:0] : 2'h0;
  wire [1:0] stat_nxt = stat_set | (irq_stat_q & ~stat_clr);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      win_flag_q <= 1'b0;
    end else begin
      win_flag_q <= win_event | (win_flag_q & ~flag_clr);
    end
  end

  // Per-bit sticky status, write one to clear
  for (genvar b = 0; b < 2; b++) begin : g_stat
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        irq_stat_q[b] <= 1'b0;
      end else begin
        irq_stat_q[b] <= stat_nxt[b];
      end
    end
  end

  // Built from the next status so the line follows the flag without a lag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_nxt & irq_mask_q);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = awc_pkg::RST_ZERO;
    case (bus.addr)
      awc_pkg::ADDR_CTRL: rd_mux = {diff_q, 3'h0, win_flag_q, 3'h0};
      awc_pkg::ADDR_GT_HI: rd_mux = gt_hi_q;
      awc_pkg::ADDR_GT_LO: rd_mux = gt_lo_q;
      awc_pkg::ADDR_LT_LO: rd_mux = lt_lo_q;
      awc_pkg::ADDR_LT_HI: rd_mux = lt_hi_q;
      awc_pkg::ADDR_RES_HI: rd_mux = res_hi_q;
      awc_pkg::ADDR_RES_LO: rd_mux = res_lo_q;
      awc_pkg::ADDR_IRQ_STAT: rd_mux = {6'h00, irq_stat_q};
      awc_pkg::ADDR_IRQ_MASK: rd_mux = {6'h00, irq_mask_q};
      default: rd_mux = awc_pkg::RST_ZERO;
    endcase
  end

  // Zero outside the reply keeps an idle bus quiet
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= awc_pkg::RST_ZERO;
    end else begin
      rdata_q <= bus.rd ? rd_mux : awc_pkg::RST_ZERO;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata = rdata_q;
  assign window_irq = irq_q;

endmodule : awc_window_cmp

/* File: sim/awc_conv_model.sv */
// Partner model: converter clock ticks and one-cycle result pulses.
// Assumes send is called from a process aligned to a rising clk edge.
`timescale 1ns/1ps
module awc_conv_model (
  input wire logic clk,
  output awc_pkg::awc_conv_s conv,
  output logic tick
);
  initial begin
    conv = '0;
    tick = 1'b0;
  end
  always @(posedge clk) tick <= !tick;
  // Early sends break the spacing on purpose; word is scrambled outside pulses
  task automatic send(input logic [15:0] w, input logic early);
    repeat (early ? 1 : awc_pkg::MIN_CONV_CLKS) @(posedge clk iff tick);
    conv <= '{1'b1, w};
    @(posedge clk);
    conv <= '{1'b0, ~w};
  endtask : send
endmodule : awc_conv_model

/* File: sim/awc_window_cmp_chk.sv */
// Checker on the window comparator ports.
// Assumes one clock domain; bound at the foot of this file.
`timescale 1ns/1ps
module awc_window_cmp_chk #(parameter int MIN_CONV = 10) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire awc_pkg::awc_bus_s bus,
  input wire logic [7:0] rdata,
  input wire awc_pkg::awc_conv_s conv,
  input wire logic conv_clk_tick,
  input wire logic diff_mode,
  input wire logic window_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  int tick_n;
  // Saturates so a long run never wraps
  always_ff @(posedge clk) tick_n <= sys_rst ? 0 : tick_n + int'(conv_clk_tick && tick_n < 15);
  chk_rst_clear: assert property ($fell(sys_rst) |-> rdata == 8'h00 && !window_irq)
    else $error("dirty reset");
  chk_lt_lo_rd: assert property (
    bus.wr && bus.addr == awc_pkg::ADDR_LT_LO ##1 bus.rd && bus.addr == awc_pkg::ADDR_LT_LO
    |=> rdata == $past(bus.wdata, 2)) else $error("bad read back");
  chk_rd_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("rdata without read");
  chk_unmap_zero: assert property (bus.rd && bus.addr == 8'h00 |=> rdata == 8'h00)
    else $error("unmapped read");
  chk_irq_sticky: assert property (window_irq && !bus.wr |=> window_irq)
    else $error("irq dropped");
  chk_irq_drop: assert property ($fell(window_irq) |-> $past(bus.wr) || $past(bus.wr, 2))
    else $error("irq fell alone");
  chk_irq_cause: assert property ($rose(window_irq) |-> $past(conv.valid, 2) ||
    $past(conv.valid, 3) || $past(bus.wr, 2) || $past(bus.wr, 3)) else $error("irq uncaused");
  chk_conv_min: assert property (window_irq |-> tick_n >= MIN_CONV)
    else $error("early result");
  cov_irq: cover property ($rose(window_irq));
  cov_lt_wr: cover property (bus.wr && bus.addr == awc_pkg::ADDR_LT_LO);
  cov_diff: cover property (conv.valid && diff_mode);
endmodule : awc_window_cmp_chk
bind awc_window_cmp awc_window_cmp_chk #(.MIN_CONV(MIN_CONV)) u_chk (.clk, .sys_rst, .bus,
  .rdata, .conv, .conv_clk_tick, .diff_mode, .window_irq);

/* File: sim/awc_window_cmp_tb.sv */
// Testbench: limit registers, both windows in both modes, early results, irq mask.
// Assumes awc_conv_model drives ticks and results.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch t=%0t %h %h", $time, a, b); end end
module awc_window_cmp_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic diff_mode = 1'b0;
  logic pend = 1'b0;
  logic cap_d = 1'b0;
  logic h, conv_clk_tick, window_irq;
  logic [7:0] rdata, d, x;
  logic [49:0] e;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  int seed = 32'hddc2;
  awc_pkg::awc_bus_s bus = '0;
  awc_pkg::awc_conv_s conv;
  localparam logic [7:0] LIM [4] = '{awc_pkg::ADDR_GT_HI, awc_pkg::ADDR_GT_LO,
    awc_pkg::ADDR_LT_HI, awc_pkg::ADDR_LT_LO};
  // Early and diff flags, greater-than, less-than, word
  localparam logic [49:0] TBL [14] = '{50'h0_0040_0080_0040, 50'h0_0040_0080_0041,
    50'h0_0040_0080_007F, 50'h0_0040_0080_0080, 50'h0_0080_0040_003F, 50'h0_0080_0040_0040,
    50'h0_0080_0040_0080, 50'h0_0080_0040_0081, 50'h1_FFFF_0040_0000, 50'h1_FFFF_0040_FFFF,
    50'h1_0040_FFFF_FFFE, 50'h1_0040_FFFF_0041, 50'h1_0040_FFFF_0000, 50'h2_0040_0080_0041};
  awc_conv_model u_conv (.clk, .conv, .tick(conv_clk_tick));
  awc_window_cmp #(.MIN_CONV(awc_pkg::MIN_CONV_CLKS)) u_dut (.clk, .sys_rst, .bus, .rdata,
    .conv, .conv_clk_tick, .diff_mode, .window_irq);
  initial begin
    forever #5 clk = !clk;
  end
  always @(posedge clk) pend <= bus.rd;
  always @(negedge clk) if (pend) begin
    x = exp_q.pop_front();
    `CHK(rdata, x)
  end
  // ----------------------------------------
  // Bus cycles and expected window
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, v);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, v);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    exp_q.push_back(v);
    @(posedge clk);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) begin
      bus <= '0;
      @(posedge clk);
    end
  endtask : idle
  // Values widened to 17 signed bits: sign-extended in diff mode, zero-extended otherwise
  function automatic logic hit(input logic s, input logic [15:0] g, l, w);
    logic signed [16:0] gv, lv, wv;
    gv = $signed({s & g[15], g});
    lv = $signed({s & l[15], l});
    wv = $signed({s & w[15], w});
    if (lv > gv) return wv > gv && wv < lv;
    return wv < gv || wv > lv;
  endfunction : hit
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(awc_pkg::ADDR_LT_LO, awc_pkg::RST_LT_BYTE);
    rd(awc_pkg::ADDR_GT_HI, awc_pkg::RST_GT_BYTE);
    rd(8'h00, 8'h00);
    rd(awc_pkg::ADDR_IRQ_MASK, awc_pkg::RST_ZERO);
    d = 8'($random(seed));
    wr(awc_pkg::ADDR_LT_LO, d);
    rd(awc_pkg::ADDR_LT_LO, d);
    for (int i = 0; i < 14; i++) begin
      e = TBL[i];
      h = hit(e[48], e[47:32], e[31:16], e[15:0]) && !e[49];
      wr(awc_pkg::ADDR_IRQ_MASK, {7'h00, i[0]});
      for (int k = 0; k < 4; k++) wr(LIM[k], e[47 - 8 * k -: 8]);
      wr(awc_pkg::ADDR_IRQ_STAT, 8'h03);
      wr(awc_pkg::ADDR_CTRL, 8'h00);
      idle(1);
      diff_mode <= e[48];
      u_conv.send(e[15:0], e[49]);
      if (!e[49]) cap_d = e[48];
      idle(3);
      rd(awc_pkg::ADDR_CTRL, {cap_d, 3'h0, h, 3'h0});
      rd(awc_pkg::ADDR_IRQ_STAT, {6'h00, !e[49], h});
      idle(2);
      `CHK(window_irq, h && i[0])
    end
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  task give_verdict();
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
endmodule : awc_window_cmp_tb
